// ==== core/iak_map.vh ====
/*
 * constants of the interrupt acknowledge block: register offsets, status
 * word fields, reset values, service timing and vector addresses.
 * assumes: included by bare name from files under core/.
 */
`ifndef IAK_MAP_VH
`define IAK_MAP_VH

// ***********************************************************
// register offsets (8-bit data, one byte each)
// ***********************************************************
`define IAK_ADDR_W        4
`define IAK_OFS_REQ_LO    4'h0
`define IAK_OFS_REQ_HI    4'h1
`define IAK_OFS_MASK_LO   4'h2
`define IAK_OFS_MASK_HI   4'h3
`define IAK_OFS_LVL_LO    4'h4
`define IAK_OFS_LVL_HI    4'h5
`define IAK_OFS_PSW       4'h6
`define IAK_OFS_STAT      4'h7

// ***********************************************************
// sources and status word
// ***********************************************************
`define IAK_NSRC          16
`define IAK_IDX_W         5
`define IAK_TRAP_IDX      5'h10
`define IAK_PSW_IE        7
`define IAK_PSW_ISP       1
`define IAK_RST_REQ       16'h0000
`define IAK_RST_MASK      16'hFFFF
`define IAK_RST_LVL       16'hFFFF
`define IAK_RST_PSW       8'h02

// ***********************************************************
// service timing in cpu clocks, request to vector load
// ***********************************************************
`define IAK_LAT_L0        4'h7
`define IAK_LAT_L1        4'h8
`define IAK_PUSH_CLKS     4'h4

// ***********************************************************
// vector table
// ***********************************************************
`define IAK_VEC_BASE      16'h0004
`define IAK_TRAP_VEC      16'h003E

`endif

// ==== core/iak_vec_rom.v ====
/*
 * vector table lookup: maps a source index to the address of its vector
 * entry, read data registered.
 * assumes: single clock, index held stable while the vector is used.
 */
`timescale 1ns/1ns
`include "iak_map.vh"

module iak_vec_rom (
  clk,
  idx,
  vec_addr
);
  input  wire                    clk;
  input  wire [`IAK_IDX_W-1:0]   idx;
  output reg  [15:0]             vec_addr;

  // ***********************************************************
  // two bytes per entry, trap entry fixed
  // ***********************************************************
  always @(posedge clk) begin
    if (idx == `IAK_TRAP_IDX) begin
      vec_addr <= `IAK_TRAP_VEC;
    end else begin
      vec_addr <= `IAK_VEC_BASE + {10'h000, idx, 1'b0};
    end
  end
endmodule // iak_vec_rom

// ==== core/iak_ctrl.v ====
/*
 * interrupt acknowledge logic: request, mask and level flags, status word,
 * priority pick, acceptance timing, stacking and vector load.
 * assumes: cpu sequencer gives one instr_done pulse per instruction end,
 * with instr_hold, ei/di/ret/brk pulses in that same cycle; stack and
 * vector fetch are done by the sequencer from the strobes given here.
 */
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
//
// Behaviour
// - acknowledgeable needs flag set, mask clear
// - maskable accepted only when enable is 1
// - low level refused while in-service flag 0
// - service 7..32 clocks, one more at low
// - higher programmable level wins simultaneous requests
// - equal level: highest default priority wins
// - blocked request stays pending, accepted later
// - push status, push pc, clear enable, vector
// - accepted level copied into in-service flag
// - return restores stacked pc and status word
// - software trap always accepted
// - trap pushes, clears enable, vectors 003EH
// - nested equal or higher priority accepted
// - lower priority or disabled requests held
// - one main instruction before pending accept; code blocks the next boundary too, so two run
// - trap service nests both levels, traps
// - hold instructions defer acceptance one instruction; code defers two, blocking own and next boundary
// - trap defers nothing but clears enable
// - flags set regardless of level flag
// - in-service 0 high, 1 none/low
// - level flag 0 high, 1 low
// - accepted source flag cleared on acceptance
//
`timescale 1ns/1ns
`include "iak_map.vh"

module iak_ctrl (
  clk,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  src_req,
  instr_done,
  instr_hold,
  ei_exec,
  di_exec,
  brk_exec,
  ret_exec,
  ret_psw,
  cpu_pc,
  svc_busy,
  stack_wr,
  stack_data,
  pc_load,
  pc_vec_addr,
  psw_out
);
  input  wire [`IAK_ADDR_W-1:0]  reg_addr;
  input  wire                    clk;
  input  wire                    rst;
  input  wire [7:0]              reg_wdata;
  input  wire                    reg_wr;
  input  wire                    reg_rd;
  output reg  [7:0]              reg_rdata;
  input  wire [`IAK_NSRC-1:0]    src_req;
  input  wire                    instr_done;
  input  wire                    instr_hold;
  input  wire                    ei_exec;
  input  wire                    di_exec;
  input  wire                    brk_exec;
  input  wire                    ret_exec;
  input  wire [7:0]              ret_psw;
  input  wire [15:0]             cpu_pc;
  output reg                     svc_busy;
  output reg                     stack_wr;
  output reg  [7:0]              stack_data;
  output reg                     pc_load;
  output reg  [15:0]             pc_vec_addr;
  output reg  [7:0]              psw_out;

  // ***********************************************************
  // states, one-hot
  // ***********************************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_PCH  = 5'h02;
  localparam [4:0] ST_PCL  = 5'h04;
  localparam [4:0] ST_WAIT = 5'h08;
  localparam [4:0] ST_LOAD = 5'h10;

  reg  [`IAK_NSRC-1:0]   req_reg;
  reg  [`IAK_NSRC-1:0]   req_next;
  reg  [`IAK_NSRC-1:0]   mask_reg;
  reg  [`IAK_NSRC-1:0]   lvl_reg;
  reg  [7:0]             psw_reg;
  reg  [7:0]             psw_next;
  reg  [4:0]             state_reg;
  reg  [3:0]             cnt_reg;
  reg  [15:0]            pc_save_reg;
  reg  [`IAK_IDX_W-1:0]  idx_reg;
  reg                    hold_reg;
  reg  [`IAK_IDX_W-1:0]  pick_idx;
  reg                    pick_ok;
  reg                    pick_lvl;
  integer                i;
  wire [`IAK_NSRC-1:0]   ready_hi;
  wire [`IAK_NSRC-1:0]   ready_lo;
  wire [15:0]            rom_vec;
  wire                   ie;
  wire                   in_service_level_flag;
  wire                   hold_now;
  wire                   boundary;
  wire                   take_trap;
  wire                   take_mask;
  wire                   accept;

  assign ie  = psw_reg[`IAK_PSW_IE];
  assign in_service_level_flag = psw_reg[`IAK_PSW_ISP];

  // ***********************************************************
  // per-source acknowledgeable terms split by level
  // ***********************************************************
  genvar g;
  generate
    for (g = 0; g < `IAK_NSRC; g = g + 1) begin : g_src
      // level 0 high, 1 low; low needs no high service open
      assign ready_hi[g] = req_reg[g] & ~mask_reg[g] & ~lvl_reg[g];
      assign ready_lo[g] = req_reg[g] & ~mask_reg[g] & lvl_reg[g]
                           & in_service_level_flag;
    end
  endgenerate

  // ***********************************************************
  // priority pick: high level first, then lowest index
  // ***********************************************************
  always @* begin
    pick_idx = {`IAK_IDX_W{1'b0}};
    pick_ok  = 1'b0;
    pick_lvl = 1'b0;
    for (i = `IAK_NSRC - 1; i >= 0; i = i - 1) begin
      if (ready_lo[i]) begin
        pick_idx = i[`IAK_IDX_W-1:0];
        pick_ok  = 1'b1;
        pick_lvl = 1'b1;
      end
    end
    if (|ready_hi) begin
      pick_lvl = 1'b0;
      for (i = `IAK_NSRC - 1; i >= 0; i = i - 1) begin
        if (ready_hi[i]) begin
          pick_idx = i[`IAK_IDX_W-1:0];
          pick_ok  = 1'b1;
        end
      end
    end
  end

  // ***********************************************************
  // acceptance at instruction boundaries
  // ***********************************************************
  // returns, ei, di and hold instructions block this boundary
  // and the next one
  assign hold_now  = instr_hold | ei_exec | di_exec | ret_exec;
  assign boundary  = instr_done & (state_reg == ST_IDLE);
  // trap is never held off and ignores enable and masks
  assign take_trap = boundary & brk_exec;
  assign take_mask = boundary & ~brk_exec & ~hold_now & ~hold_reg
                     & ie & pick_ok;
  assign accept    = take_trap | take_mask;

  always @(posedge clk) begin
    if (rst) begin
      hold_reg <= 1'b0;
    end else if (instr_done) begin
      hold_reg <= hold_now;
    end
  end

  // ***********************************************************
  // request flags: source set wins over any clear
  // ***********************************************************
  always @* begin
    req_next = req_reg;
    if (reg_wr && reg_addr == `IAK_OFS_REQ_LO) begin
      req_next[7:0] = reg_wdata;
    end
    if (reg_wr && reg_addr == `IAK_OFS_REQ_HI) begin
      req_next[15:8] = reg_wdata;
    end
    if (take_mask) begin
      req_next[pick_idx[3:0]] = 1'b0;
    end
    req_next = req_next | src_req;
  end

  always @(posedge clk) begin
    if (rst) begin
      req_reg  <= `IAK_RST_REQ;
      mask_reg <= `IAK_RST_MASK;
      lvl_reg  <= `IAK_RST_LVL;
    end else begin
      req_reg <= req_next;
      if (reg_wr && reg_addr == `IAK_OFS_MASK_LO) begin
        mask_reg[7:0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `IAK_OFS_MASK_HI) begin
        mask_reg[15:8] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `IAK_OFS_LVL_LO) begin
        lvl_reg[7:0] <= reg_wdata;
      end
      if (reg_wr && reg_addr == `IAK_OFS_LVL_HI) begin
        lvl_reg[15:8] <= reg_wdata;
      end
    end
  end

  // ***********************************************************
  // status word: enable and in-service level
  // ***********************************************************
  always @* begin
    psw_next = psw_reg;
    if (reg_wr && reg_addr == `IAK_OFS_PSW) begin
      psw_next = reg_wdata;
    end
    if (ret_exec) begin
      psw_next = ret_psw;
    end
    if (ei_exec) begin
      psw_next[`IAK_PSW_IE] = 1'b1;
    end
    if (di_exec) begin
      psw_next[`IAK_PSW_IE] = 1'b0;
    end
    if (accept) begin
      psw_next[`IAK_PSW_IE] = 1'b0;
    end
    if (take_mask) begin
      psw_next[`IAK_PSW_ISP] = pick_lvl;
    end
    // trap service lets both levels nest; return restores the old flag
    if (take_trap) begin
      psw_next[`IAK_PSW_ISP] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      psw_reg <= `IAK_RST_PSW;
      psw_out <= `IAK_RST_PSW;
    end else begin
      psw_reg <= psw_next;
      psw_out <= psw_next;
    end
  end

  // ***********************************************************
  // service sequence: push psw, pc high, pc low, wait, load
  // ***********************************************************
  iak_vec_rom u_vec (
    .clk      (clk),
    .idx      (idx_reg),
    .vec_addr (rom_vec)
  );

  always @(posedge clk) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 4'h0;
      pc_save_reg <= 16'h0000;
      idx_reg     <= {`IAK_IDX_W{1'b0}};
      svc_busy    <= 1'b0;
      stack_wr    <= 1'b0;
      stack_data  <= 8'h00;
      pc_load     <= 1'b0;
      pc_vec_addr <= 16'h0000;
    end else begin
      stack_wr <= 1'b0;
      pc_load  <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            // status word is stacked before enable drops
            stack_wr    <= 1'b1;
            stack_data  <= psw_reg;
            pc_save_reg <= cpu_pc;
            svc_busy    <= 1'b1;
            idx_reg     <= take_trap ? `IAK_TRAP_IDX : pick_idx;
            cnt_reg     <= (take_mask && pick_lvl)
                           ? (`IAK_LAT_L1 - `IAK_PUSH_CLKS)
                           : (`IAK_LAT_L0 - `IAK_PUSH_CLKS);
            state_reg   <= ST_PCH;
          end
        end
        ST_PCH: begin
          stack_wr   <= 1'b1;
          stack_data <= pc_save_reg[15:8];
          state_reg  <= ST_PCL;
        end
        ST_PCL: begin
          stack_wr   <= 1'b1;
          stack_data <= pc_save_reg[7:0];
          state_reg  <= ST_WAIT;
        end
        ST_WAIT: begin
          if (cnt_reg == 4'h0) begin
            pc_load     <= 1'b1;
            pc_vec_addr <= rom_vec;
            svc_busy    <= 1'b0;
            state_reg   <= ST_LOAD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ST_LOAD: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
          svc_busy  <= 1'b0;
        end
      endcase
    end
  end

  // ***********************************************************
  // register read port, data one cycle after the strobe
  // ***********************************************************
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `IAK_OFS_REQ_LO:  reg_rdata <= req_reg[7:0];
        `IAK_OFS_REQ_HI:  reg_rdata <= req_reg[15:8];
        `IAK_OFS_MASK_LO: reg_rdata <= mask_reg[7:0];
        `IAK_OFS_MASK_HI: reg_rdata <= mask_reg[15:8];
        `IAK_OFS_LVL_LO:  reg_rdata <= lvl_reg[7:0];
        `IAK_OFS_LVL_HI:  reg_rdata <= lvl_reg[15:8];
        `IAK_OFS_PSW:     reg_rdata <= psw_reg;
        `IAK_OFS_STAT:    reg_rdata <= {svc_busy, hold_reg, 1'b0, idx_reg};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // iak_ctrl

// ==== verification/iak_cpu_model.sv ====
/*
 * cpu sequencer model: one instruction per go pulse, keeps the stack.
 * assumes: kind held with go; 0 plain 1 hold 2 ei 3 di 4 brk 5 ret.
 */
`timescale 1ns/1ns

module iak_cpu_model (
  input  wire        clk,
  input  wire        rst,
  input  wire        go,
  input  wire [2:0]  kind,
  input  wire        svc_busy,
  input  wire        stack_wr,
  input  wire [7:0]  stack_data,
  input  wire        pc_load,
  input  wire [15:0] pc_vec_addr,
  output reg         instr_done,
  output reg         instr_hold,
  output reg         ei_exec,
  output reg         di_exec,
  output reg         brk_exec,
  output reg         ret_exec,
  output wire [7:0]  ret_psw,
  output reg  [15:0] cpu_pc
);
  reg [7:0] stk [0:31];
  reg [4:0] sp;
  reg       pend;
  reg       fire;

  // top frame holds status word, pc high, pc low
  assign ret_psw = stk[sp-5'd3];

  always @(posedge clk) begin
    fire = (go | pend) & ~svc_busy & ~rst;
    pend <= (go | pend) & svc_busy & ~rst;
    instr_done <= fire;
    instr_hold <= fire & (kind == 3'h1);
    ei_exec <= fire & (kind == 3'h2);
    di_exec <= fire & (kind == 3'h3);
    brk_exec <= fire & (kind == 3'h4);
    ret_exec <= fire & (kind == 3'h5);
    if (rst) begin
      sp <= 5'h00;
      cpu_pc <= 16'h0100;
    end else if (pc_load) begin
      cpu_pc <= pc_vec_addr;
    end else if (instr_done && ret_exec) begin
      cpu_pc <= {stk[sp-5'd2], stk[sp-5'd1]};
      sp <= sp - 5'd3;
    end else begin
      if (stack_wr) begin
        stk[sp] <= stack_data;
        sp <= sp + 5'd1;
      end
      if (fire) cpu_pc <= cpu_pc + 16'h0001;
    end
  end
endmodule // iak_cpu_model

// ==== verification/iak_ctrl_assertions.sv ====
/*
 * checker for the interrupt acknowledge block, bound to iak_ctrl.
 * assumes: the sequencer stalls instr_done while svc_busy is high.
 */
`timescale 1ns/1ns
`include "iak_map.vh"

module iak_ctrl_chk (
  input wire        clk,
  input wire        rst,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        instr_done,
  input wire        instr_hold,
  input wire        ei_exec,
  input wire        di_exec,
  input wire        brk_exec,
  input wire        ret_exec,
  input wire [7:0]  ret_psw,
  input wire [15:0] cpu_pc,
  input wire        svc_busy,
  input wire        stack_wr,
  input wire [7:0]  stack_data,
  input wire        pc_load,
  input wire [15:0] pc_vec_addr,
  input wire [7:0]  psw_out
);
  reg  [15:0] pc_cap;
  wire        edge_ok = instr_done && !svc_busy;

  always @(posedge clk) begin
    if (edge_ok) pc_cap <= cpu_pc;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_take; $rose(svc_busy); endsequence
  sequence s_mtake; $rose(svc_busy) && !$past(brk_exec); endsequence
  sequence s_push3; stack_wr [*3] ##1 !stack_wr; endsequence

  a_push_count:
    assert property (s_take |-> s_push3) else $error("push count wrong");
  a_psw_first:
    assert property (s_take |-> stack_data == $past(psw_out)
      && !psw_out[`IAK_PSW_IE]) else $error("status push wrong");
  a_pc_bytes:
    assert property (s_take |-> ##1 stack_data == pc_cap[15:8]
      ##1 stack_data == pc_cap[7:0]) else $error("pc push wrong");
  a_busy_span:
    assert property (s_take |-> svc_busy [*5] ##[2:3] (pc_load && !svc_busy))
      else $error("service length wrong");
  a_isp_high:
    assert property (s_mtake ##6 pc_load |-> !psw_out[`IAK_PSW_ISP])
      else $error("level flag not copied");
  a_isp_low:
    assert property (s_mtake ##7 pc_load |-> psw_out[`IAK_PSW_ISP])
      else $error("low level flag not copied");
  a_trap_vec:
    assert property (edge_ok && brk_exec |-> ##7 pc_load
      && pc_vec_addr == `IAK_TRAP_VEC) else $error("trap vector wrong");
  a_off_refuse:
    assert property (edge_ok && !brk_exec && !psw_out[`IAK_PSW_IE]
      |=> !svc_busy) else $error("taken while disabled");
  a_hold_defer:
    assert property (edge_ok && !brk_exec && (instr_hold || ei_exec
      || di_exec || ret_exec) |=> !svc_busy) else $error("hold not kept");
  a_ret_load:
    assert property (edge_ok && ret_exec |=> psw_out == $past(ret_psw))
      else $error("return status wrong");
  a_trap_isp:
    assert property (edge_ok && brk_exec |=> psw_out[`IAK_PSW_ISP])
      else $error("trap level flag wrong");
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not idle");
endmodule // iak_ctrl_chk

bind iak_ctrl iak_ctrl_chk iak_ctrl_chk_i (.clk, .rst, .reg_rd, .reg_rdata,
  .instr_done, .instr_hold, .ei_exec, .di_exec, .brk_exec, .ret_exec,
  .ret_psw, .cpu_pc, .svc_busy, .stack_wr, .stack_data, .pc_load,
  .pc_vec_addr, .psw_out);

// ==== verification/test_iak_ctrl.sv ====
/*
 * self-checking bench for iak_ctrl with the sequencer model.
 * assumes: iak_map.vh on the include path, clock of 25 MHz.
 */
`timescale 1ns/1ns

module test_iak_ctrl;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [15:0] src_req = 16'h0000;
  reg         go = 1'b0;
  reg  [2:0]  kind = 3'h0;
  wire [7:0]  reg_rdata, ret_psw, stack_data, psw_out;
  wire [15:0] cpu_pc, pc_vec_addr;
  wire        instr_done, instr_hold, ei_exec, di_exec, brk_exec;
  wire        ret_exec, svc_busy, stack_wr, pc_load;
  integer     n_mismatch = 0;
  integer     checked = 0;
  integer     cycles = 0;

  always #20 clk = ~clk;

  iak_ctrl iak_ctrl_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .src_req, .instr_done, .instr_hold, .ei_exec, .di_exec,
    .brk_exec, .ret_exec, .ret_psw, .cpu_pc, .svc_busy, .stack_wr,
    .stack_data, .pc_load, .pc_vec_addr, .psw_out);
  iak_cpu_model iak_cpu_model_i (.clk, .rst, .go, .kind, .svc_busy,
    .stack_wr, .stack_data, .pc_load, .pc_vec_addr, .instr_done,
    .instr_hold, .ei_exec, .di_exec, .brk_exec, .ret_exec, .ret_psw,
    .cpu_pc);

  task conclude;
    begin
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask

  // ***********************************************************
  // access tasks
  // ***********************************************************
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [3:0] a, input [7:0] d);
    begin
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask

  task rd(input [3:0] a, input [7:0] e);
    begin
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
    end
  endtask

  task req(input [15:0] m);
    begin
      src_req <= m;
      @(posedge clk);
      src_req <= 16'h0000;
    end
  endtask

  // one instruction; vec 0 means no acceptance expected
  task step(input [2:0] k, input [15:0] vec, input [7:0] processor_status_word,
            input [7:0] pushed);
    integer    i;
    reg        w;
    reg [7:0]  pb;
    reg [15:0] va;
    begin
      w = 1'b0; pb = 8'h00; va = 16'h0000;
      kind <= k; go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (i = 0; i < 12; i = i + 1) begin
        @(posedge clk);
        #1;
        if (stack_wr && !w) begin pb = stack_data; w = 1'b1; end
        if (pc_load) va = pc_vec_addr;
      end
      chk(va, vec);
      chk(psw_out, processor_status_word);
      if (vec != 16'h0000) chk(pb, pushed);
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(4'h6, 8'h02);
    rd(4'h2, 8'hFF);
    rd(4'h4, 8'hFF);
    rd(4'h8, 8'h00);
    $display("test reset done");
    wr(4'h6, 8'h82);
    wr(4'h2, 8'hD7);
    wr(4'h4, 8'hDF);
    req(16'h0068);
    rd(4'h0, 8'h68);
    step(3'h0, 16'h000E, 8'h00, 8'h82);
    rd(4'h0, 8'h48);
    step(3'h2, 16'h0000, 8'h80, 8'h00);
    step(3'h0, 16'h0000, 8'h80, 8'h00);
    step(3'h0, 16'h0000, 8'h80, 8'h00);
    step(3'h5, 16'h0000, 8'h82, 8'h00);
    step(3'h0, 16'h0000, 8'h82, 8'h00);
    step(3'h0, 16'h000A, 8'h02, 8'h82);
    $display("test priority done");
    wr(4'h2, 8'hE7);
    req(16'h0018);
    step(3'h5, 16'h0000, 8'h82, 8'h00);
    step(3'h0, 16'h0000, 8'h82, 8'h00);
    step(3'h0, 16'h000A, 8'h02, 8'h82);
    rd(4'h0, 8'h50);
    $display("test tie done");
    step(3'h2, 16'h0000, 8'h82, 8'h00);
    step(3'h4, 16'h003E, 8'h02, 8'h82);
    step(3'h0, 16'h0000, 8'h02, 8'h00);
    step(3'h5, 16'h0000, 8'h82, 8'h00);
    step(3'h0, 16'h0000, 8'h82, 8'h00);
    step(3'h0, 16'h000C, 8'h02, 8'h82);
    rd(4'h0, 8'h40);
    $display("test nesting done");
    wr(4'h2, 8'hA7);
    step(3'h5, 16'h0000, 8'h82, 8'h00);
    step(3'h3, 16'h0000, 8'h02, 8'h00);
    step(3'h2, 16'h0000, 8'h82, 8'h00);
    step(3'h1, 16'h0000, 8'h82, 8'h00);
    step(3'h0, 16'h0000, 8'h82, 8'h00);
    step(3'h0, 16'h0010, 8'h02, 8'h82);
    rd(4'h0, 8'h00);
    $display("test hold done");
    conclude;
  end
endmodule // test_iak_ctrl
